// File: hdl/irs_pkg.sv
// Constants, register layout and state codes of the serial register slave.
// Assumes a single 125 MHz core clock shared by every module that uses it.
`default_nettype none

package irs_pkg;

  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned TICK_HZ      = 1_000_000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / TICK_HZ;
  localparam int unsigned SCL_TMO_MS   = 35;
  localparam int unsigned SCL_TMO_US   = SCL_TMO_MS * 1000;

  localparam logic [5:0] OFS_MODE      = 6'h02;
  localparam logic [5:0] OFS_LINK_CTRL = 6'h07;
  localparam logic [5:0] OFS_WPROT     = 6'h0d;
  localparam logic [5:0] OFS_ADDR_CFG  = 6'h14;
  localparam logic [5:0] OFS_LINK_STAT = 6'h3f;
  localparam logic [5:0] PROT_LO       = 6'h0e;
  localparam logic [5:0] PROT_HI       = 6'h2f;

  // One bit per register index that exists in the map.
  localparam logic [63:0] REG_EXIST    = 64'h000f_0000_001b_fffe;

  localparam int unsigned WMODE_BIT    = 7;
  localparam int unsigned HSM_BIT      = 6;
  localparam int unsigned TMO_EN_BIT   = 4;
  localparam int unsigned ADDR_UP_MSB  = 3;
  localparam int unsigned ADDR_UP_LSB  = 0;

  localparam logic [7:0] RST_MODE      = 8'h70;
  localparam logic [7:0] RST_ADDR_CFG  = 8'h0d;
  localparam logic [7:0] RST_OTHER     = 8'h00;
  // Arbitrary value; writing it to the protection register lifts the lock.
  localparam logic [7:0] UNLOCK_KEY    = 8'h5a;

  localparam logic [2:0] DEV_ADDR_LOW  = 3'h0;
  localparam logic [4:0] MCODE_PREFIX  = 5'h01;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  localparam logic [1:0] AXI_OKAY      = 2'h0;
  localparam logic [1:0] AXI_SLVERR    = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_DEVADR = 3'b001,
    ST_DEVACK = 3'b010,
    ST_RXBYTE = 3'b011,
    ST_RXACK  = 3'b100,
    ST_TXBYTE = 3'b101,
    ST_TXACK  = 3'b110,
    ST_IGNORE = 3'b111
  } irs_state_t;

  function automatic logic [7:0] rst_val(input logic [5:0] idx);
    logic [7:0] v;
    v = RST_OTHER;
    if (idx == OFS_MODE) begin
      v = RST_MODE;
    end else if (idx == OFS_ADDR_CFG) begin
      v = RST_ADDR_CFG;
    end
    return v;
  endfunction

endpackage

`default_nettype wire

// File: hdl/irs_sync.sv
// Two-stage synchroniser for levels that arrive from outside the core clock.
// Assumes the inputs change slowly compared with the core clock.
`default_nettype none

module irs_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Pins idle high on an open-drain bus, so both stages reset high.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '1;
      q        <= '1;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// File: hdl/irs_scl_tmo.sv
// Watchdog that flags a serial clock held low for too long.
// Assumes scl_low is already synchronised to clk.
`default_nettype none

module irs_scl_tmo #(
  parameter int unsigned TMO_US = irs_pkg::SCL_TMO_US
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic scl_low,
  output logic      expired
);

  logic [6:0]  div_reg;
  logic [15:0] cnt_reg;
  wire         tick    = (div_reg == 7'(irs_pkg::TICK_CYCLES - 1));
  wire         armed   = enable & scl_low;
  wire         at_end  = (cnt_reg == 16'(TMO_US));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 7'h00;
      cnt_reg <= 16'h0000;
      expired <= 1'b0;
    end else begin
      div_reg <= tick ? 7'h00 : div_reg + 7'h01;
      if (!armed) begin
        cnt_reg <= 16'h0000;
      end else if (tick && cnt_reg != 16'hffff) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
      expired <= armed & tick & at_end;
    end
  end

endmodule

`default_nettype wire

// File: hdl/irs_i2c_slave.sv
// Byte-wide register file reached from a two-wire serial bus and from AXI4-Lite.
// Assumes an external pull-up on both bus lines and core mode inputs on clk.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`default_nettype none

module irs_i2c_slave #(
  parameter int unsigned TMO_US = irs_pkg::SCL_TMO_US
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        mode_active_or_sleep,
  input  wire logic        io_supply_rail_ok,
  output logic             hs_mode,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [1:0]         pin_s;
  logic               scl_q;
  logic               sda_q;
  logic               tmo_hit;
  logic               idle_lvl_reg;
  logic [7:0]         regs [64];

  irs_pkg::irs_state_t state_reg;
  irs_pkg::irs_state_t state_next;
  logic [3:0]         cnt_reg;
  logic [3:0]         cnt_next;
  logic [7:0]         sh_reg;
  logic [7:0]         sh_next;
  logic [7:0]         ptr_reg;
  logic [7:0]         ptr_next;
  logic               rw_reg;
  logic               rw_next;
  logic               exp_ptr_reg;
  logic               exp_ptr_next;
  logic               alt_reg;
  logic               alt_next;
  logic               hs_reg;
  logic               hs_next;
  logic               ack_reg;
  logic               ack_next;
  logic               oe_reg;
  logic               oe_next;

  logic               aw_held_reg;
  logic [5:0]         aw_idx_reg;
  logic               w_held_reg;
  logic [7:0]         w_data_reg;
  logic               w_en_reg;

  irs_sync #(
    .W (2)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({scl_i, sda_i}),
    .q     (pin_s)
  );

  wire scl_s     = pin_s[1];
  wire sda_s     = pin_s[0];
  wire scl_rise  = scl_s & ~scl_q;
  wire scl_fall  = ~scl_s & scl_q;
  wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
  wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

  wire [7:0] link_ctrl = regs[irs_pkg::OFS_LINK_CTRL];
  wire [7:0] addr_cfg  = regs[irs_pkg::OFS_ADDR_CFG];
  wire       hsm       = link_ctrl[irs_pkg::HSM_BIT];
  wire [3:0] addr_up   = addr_cfg[irs_pkg::ADDR_UP_MSB:irs_pkg::ADDR_UP_LSB];

  wire if_ok     = mode_active_or_sleep & io_supply_rail_ok;

  irs_scl_tmo #(
    .TMO_US (TMO_US)
  ) u_tmo (
    .clk     (clk),
    .rst_b   (rst_b),
    .enable  (link_ctrl[irs_pkg::TMO_EN_BIT] & if_ok),
    .scl_low (~scl_s),
    .expired (tmo_hit)
  );

  wire addr_match = (sh_reg[7:4] == addr_up) && (sh_reg[3:1] == irs_pkg::DEV_ADDR_LOW);
  wire mcode_seen = (sh_reg[7:3] == irs_pkg::MCODE_PREFIX);
  wire byte_done  = (cnt_reg == irs_pkg::BYTE_BITS);

  wire [7:0] rd_byte = (ptr_reg[7:6] == 2'b00) ? regs[ptr_reg[5:0]] : 8'h00;

  wire rx_store = scl_fall & (state_reg == irs_pkg::ST_RXBYTE) & byte_done;
  wire i2c_wr   = rx_store & ~exp_ptr_reg & (ptr_reg[7:6] == 2'b00) & if_ok & ~tmo_hit;

  // A serial write always wins the single write port; the bus write waits a cycle.
  wire       axi_go  = aw_held_reg & w_held_reg & ~i2c_wr;
  wire       wr_en   = i2c_wr | (axi_go & w_en_reg);
  wire [5:0] wr_idx  = i2c_wr ? ptr_reg[5:0] : aw_idx_reg;
  wire [7:0] wr_data = i2c_wr ? sh_reg : w_data_reg;

  wire locked    = (regs[irs_pkg::OFS_WPROT] != irs_pkg::UNLOCK_KEY);
  wire in_prot   = (wr_idx >= irs_pkg::PROT_LO) && (wr_idx <= irs_pkg::PROT_HI);
  wire wr_allow  = irs_pkg::REG_EXIST[wr_idx] & ~(locked & in_prot);
  wire [63:0] wr_hit = {63'h0, wr_en & wr_allow} << wr_idx;

  for (genvar i = 0; i < 64; i++) begin : g_reg
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        regs[i] <= irs_pkg::rst_val(6'(i));
      end else if (wr_hit[i]) begin
        regs[i] <= wr_data;
      end
    end
  end

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    sh_next      = sh_reg;
    ptr_next     = ptr_reg;
    rw_next      = rw_reg;
    exp_ptr_next = exp_ptr_reg;
    alt_next     = alt_reg;
    hs_next      = hs_reg;
    ack_next     = ack_reg;
    oe_next      = oe_reg;
    if (!if_ok || tmo_hit) begin
      state_next   = irs_pkg::ST_IDLE;
      cnt_next     = 4'h0;
      sh_next      = 8'h00;
      rw_next      = 1'b0;
      exp_ptr_next = 1'b0;
      hs_next      = 1'b0;
      oe_next      = 1'b0;
    end else if (bus_start) begin
      state_next = irs_pkg::ST_DEVADR;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
      if (state_reg == irs_pkg::ST_IDLE) begin
        alt_next = link_ctrl[irs_pkg::WMODE_BIT];
      end
    end else if (bus_stop) begin
      state_next = irs_pkg::ST_IDLE;
      oe_next    = 1'b0;
      hs_next    = 1'b0;
    end else if (scl_rise) begin
      unique case (state_reg)
        irs_pkg::ST_DEVADR, irs_pkg::ST_RXBYTE: begin
          sh_next  = {sh_reg[6:0], sda_s};
          cnt_next = cnt_reg + 4'h1;
        end
        irs_pkg::ST_TXBYTE: begin
          cnt_next = cnt_reg + 4'h1;
        end
        irs_pkg::ST_TXACK: begin
          ack_next = ~sda_s;
          if (!sda_s) begin
            ptr_next = ptr_reg + 8'h01;
          end
        end
        irs_pkg::ST_IDLE, irs_pkg::ST_DEVACK, irs_pkg::ST_RXACK, irs_pkg::ST_IGNORE: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_reg)
        irs_pkg::ST_DEVADR: begin
          if (byte_done) begin
            if (addr_match) begin
              state_next = irs_pkg::ST_DEVACK;
              oe_next    = 1'b1;
              rw_next    = sh_reg[0];
            end else begin
              if (mcode_seen) begin
                hs_next = 1'b1;
              end
              state_next = irs_pkg::ST_IGNORE;
            end
          end
        end
        irs_pkg::ST_DEVACK: begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            state_next = irs_pkg::ST_TXBYTE;
            oe_next    = ~rd_byte[7];
            sh_next    = {rd_byte[6:0], 1'b0};
          end else begin
            state_next   = irs_pkg::ST_RXBYTE;
            oe_next      = 1'b0;
            exp_ptr_next = 1'b1;
          end
        end
        irs_pkg::ST_RXBYTE: begin
          if (byte_done) begin
            state_next = irs_pkg::ST_RXACK;
            oe_next    = 1'b1;
            if (exp_ptr_reg) begin
              ptr_next     = sh_reg;
              exp_ptr_next = 1'b0;
            end else if (alt_reg) begin
              exp_ptr_next = 1'b1;
            end else begin
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        irs_pkg::ST_RXACK: begin
          state_next = irs_pkg::ST_RXBYTE;
          cnt_next   = 4'h0;
          oe_next    = 1'b0;
        end
        irs_pkg::ST_TXBYTE: begin
          if (byte_done) begin
            state_next = irs_pkg::ST_TXACK;
            oe_next    = 1'b0;
          end else begin
            oe_next = ~sh_reg[7];
            sh_next = {sh_reg[6:0], 1'b0};
          end
        end
        irs_pkg::ST_TXACK: begin
          if (ack_reg) begin
            state_next = irs_pkg::ST_TXBYTE;
            cnt_next   = 4'h0;
            oe_next    = ~rd_byte[7];
            sh_next    = {rd_byte[6:0], 1'b0};
          end else begin
            state_next = irs_pkg::ST_IGNORE;
            oe_next    = 1'b0;
          end
        end
        irs_pkg::ST_IDLE, irs_pkg::ST_IGNORE: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= irs_pkg::ST_IDLE;
      cnt_reg     <= 4'h0;
      sh_reg      <= 8'h00;
      ptr_reg     <= 8'h00;
      rw_reg      <= 1'b0;
      exp_ptr_reg <= 1'b0;
      alt_reg     <= 1'b0;
      hs_reg      <= 1'b0;
      ack_reg     <= 1'b0;
      oe_reg      <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      sh_reg      <= sh_next;
      ptr_reg     <= ptr_next;
      rw_reg      <= rw_next;
      exp_ptr_reg <= exp_ptr_next;
      alt_reg     <= alt_next;
      hs_reg      <= hs_next;
      ack_reg     <= ack_next;
      oe_reg      <= oe_next;
    end
  end

  // The data line is only ever pulled low, so its drive level is a constant flop.
  // clock line never driven
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_lvl_reg <= 1'b0;
    end else begin
      idle_lvl_reg <= 1'b0;
    end
  end

  assign sda_oe = oe_reg;
  assign sda_o  = idle_lvl_reg;
  assign scl_o  = idle_lvl_reg;
  assign scl_oe = idle_lvl_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_mode <= 1'b0;
    end else begin
      hs_mode <= if_ok & (hs_reg | hsm);
    end
  end

  // AXI4-Lite slave: one write and one read in flight, answer a read one cycle and a write two cycles after taking.
  wire aw_hs        = s_axi_awvalid & s_axi_awready;
  wire w_hs         = s_axi_wvalid & s_axi_wready;
  wire ar_hs        = s_axi_arvalid & s_axi_arready;
  wire aw_held_next = aw_hs | (aw_held_reg & ~axi_go);
  wire w_held_next  = w_hs | (w_held_reg & ~axi_go);
  wire bvalid_next  = axi_go | (s_axi_bvalid & ~s_axi_bready);
  wire rvalid_next  = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  wire [5:0] ar_idx  = s_axi_araddr[7:2];
  wire       ar_stat = (ar_idx == irs_pkg::OFS_LINK_STAT);
  wire       ar_ok   = irs_pkg::REG_EXIST[ar_idx] | ar_stat;
  wire [7:0] stat    = {5'h00, hs_reg, state_reg != irs_pkg::ST_IDLE, locked};
  wire [7:0] ar_byte = ar_stat ? stat : regs[ar_idx];
  wire       aw_ok   = irs_pkg::REG_EXIST[aw_idx_reg];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= 6'h00;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_en_reg    <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      if (aw_hs) begin
        aw_idx_reg <= s_axi_awaddr[7:2];
      end
      if (w_hs) begin
        w_data_reg <= s_axi_wdata[7:0];
        w_en_reg   <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= irs_pkg::AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= irs_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_next & ~bvalid_next;
      s_axi_wready  <= ~w_held_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (axi_go) begin
        s_axi_bresp <= aw_ok ? irs_pkg::AXI_OKAY : irs_pkg::AXI_SLVERR;
      end
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
      if (ar_hs) begin
        s_axi_rdata <= {24'h00_0000, ar_ok ? ar_byte : 8'h00};
        s_axi_rresp <= ar_ok ? irs_pkg::AXI_OKAY : irs_pkg::AXI_SLVERR;
      end
    end
  end

endmodule

`default_nettype wire

// File: verification/irs_i2c_slave_checker.sv
// Concurrent checks on the ports of the serial register slave.
// Assumes it is bound into every irs_i2c_slave instance.
`default_nettype none

module irs_i2c_slave_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        mode_active_or_sleep,
  input wire logic        io_supply_rail_ok,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_gap;
    s_axi_arvalid && s_axi_arready && !irs_pkg::REG_EXIST[s_axi_araddr[7:2]]
      && s_axi_araddr[7:2] != irs_pkg::OFS_LINK_STAT;
  endsequence

  property p_no_scl; !scl_oe && !scl_o; endproperty
  property p_sda_low_only; !sda_o; endproperty
  property p_sda_edge; $changed(sda_oe) |-> !scl_i; endproperty
  property p_off; (!mode_active_or_sleep || !io_supply_rail_ok) |-> ##[1:2] !sda_oe; endproperty
  property p_b_after; s_wr_take |-> ##[1:3] s_axi_bvalid; endproperty
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_next; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_r_gap; s_rd_gap |=> s_axi_rdata == 32'h0 && s_axi_rresp == irs_pkg::AXI_SLVERR;
  endproperty

  a_no_scl: assert property (p_no_scl) else $error("clock line driven");
  a_sda_low_only: assert property (p_sda_low_only) else $error("data driven high");
  a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
  a_off: assert property (p_off) else $error("data driven while disabled");
  a_b_after: assert property (p_b_after) else $error("write response late");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_next: assert property (p_r_next) else $error("read response late");
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  a_r_upper: assert property (p_r_upper) else $error("read upper bits set");
  a_r_gap: assert property (p_r_gap) else $error("missing register not zero");
endmodule

bind irs_i2c_slave irs_i2c_slave_checker chk_u (.*);

`default_nettype wire

// File: verification/irs_host_model.sv
// Behavioural bus host that masters the two-wire link at a 125 ns bit period.
// Assumes the bench resolves SDA from both pull-down drivers with a pull-up.
`default_nettype none

module irs_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real Q = 31.25;

  // The clock stands high between frames, as a real host leaves it.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic put(input logic b, output logic r);
    #Q sda_low = !b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
  endtask

  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask

  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask

  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put(d[i], r);
    put(1'b1, r);
    ack = !r;
  endtask

  task automatic rb(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put(1'b1, d[i]);
    put(!mack, r);
  endtask
endmodule

`default_nettype wire

// File: verification/irs_i2c_slave_tb_top.sv
// Self-checking bench: a bus host on the serial side and AXI4-Lite tasks on the other.
// Assumes the checker is bound into the design and the host model is compiled alongside.
`default_nettype none

module irs_i2c_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = irs_pkg::AXI_OKAY;
  localparam logic [1:0] ER = irs_pkg::AXI_SLVERR;
  localparam logic [7:0] LC = {2'b00, irs_pkg::OFS_LINK_CTRL};
  localparam logic [7:0] DEV_W = 8'hd0;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        mode_active_or_sleep = 1'b1;
  logic        io_supply_rail_ok = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        scl_o, scl_oe, sda_o, sda_oe, hs_mode, host_scl, host_low, ak;
  wire         scl_i = host_scl & !scl_oe;
  wire         sda_i = !(host_low | sda_oe);
  int          err_total = 0;
  int          n_compared = 0;

  irs_i2c_slave #(.TMO_US(20)) dut_u (.*);
  irs_host_model host_u (.scl(host_scl), .sda_low(host_low), .sda(sda_i));

  always #4 clk = ~clk;

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [5:0] i, input logic [7:0] v, input logic [1:0] er);
    logic a, w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (!a && s_axi_awready) begin
        a = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(a && w));
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({6'h0, s_axi_bresp}, {6'h0, er});
  endtask

  task automatic axi_rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata[7:0], e);
    chk({6'h0, s_axi_rresp}, {6'h0, er});
  endtask

  task automatic frame(input logic [7:0] q[$], input logic ea);
    logic k;
    host_u.start();
    foreach (q[j]) begin
      host_u.wb(q[j], k);
      chk({7'h0, k}, {7'h0, ea});
    end
    host_u.stop();
  endtask

  task automatic i2c_rd(input logic [7:0] p, input logic [7:0] e[$]);
    logic k;
    logic [7:0] v;
    host_u.start();
    host_u.wb(DEV_W, k);
    host_u.wb(p, k);
    host_u.start();
    host_u.wb(DEV_W | 8'h01, k);
    chk({7'h0, k}, 8'h01);
    foreach (e[j]) begin
      host_u.rb(j < e.size() - 1, v);
      chk(v, e[j]);
    end
    host_u.stop();
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole sequence needs well under half of this span.
  initial begin
    #300_000;
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    axi_rd(irs_pkg::OFS_MODE, irs_pkg::RST_MODE, OK);
    axi_rd(irs_pkg::OFS_ADDR_CFG, irs_pkg::RST_ADDR_CFG, OK);
    axi_rd(irs_pkg::OFS_WPROT, 8'h00, OK);
    axi_rd(6'h12, 8'h00, ER);
    frame({DEV_W, 8'h04, 8'h55}, 1'b1);
    axi_rd(6'h04, 8'h55, OK);
    frame({DEV_W, 8'h08, 8'ha1, 8'ha2, 8'ha3}, 1'b1);
    axi_wr(6'h01, 8'hc1, OK);
    i2c_rd(8'h00, {8'h00, 8'hc1, irs_pkg::RST_MODE});
    i2c_rd(8'h08, {8'ha1, 8'ha2, 8'ha3});
    frame({8'ha0}, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      mode_active_or_sleep <= k[0];
      io_supply_rail_ok <= !k[0];
      frame({DEV_W}, 1'b0);
      @(posedge clk);
      mode_active_or_sleep <= 1'b1;
      io_supply_rail_ok <= 1'b1;
    end
    frame({DEV_W, 8'h0e, 8'h77}, 1'b1);
    axi_wr(6'h0e, 8'h66, OK);
    axi_rd(6'h0e, 8'h00, OK);
    axi_wr(irs_pkg::OFS_WPROT, irs_pkg::UNLOCK_KEY, OK);
    frame({DEV_W, 8'h0e, 8'h77}, 1'b1);
    // The address field sits inside the protected range, so it only moves while unlocked.
    axi_wr(irs_pkg::OFS_ADDR_CFG, 8'h0c, OK);
    frame({8'hc0}, 1'b1);
    frame({DEV_W}, 1'b0);
    axi_wr(irs_pkg::OFS_ADDR_CFG, irs_pkg::RST_ADDR_CFG, OK);
    axi_wr(irs_pkg::OFS_WPROT, 8'h00, OK);
    axi_rd(6'h0e, 8'h77, OK);
    axi_wr(irs_pkg::OFS_ADDR_CFG, 8'h0c, OK);
    axi_rd(irs_pkg::OFS_ADDR_CFG, irs_pkg::RST_ADDR_CFG, OK);
    frame({DEV_W, LC, 8'h80, 8'h44}, 1'b1);
    axi_rd(6'h08, 8'h44, OK);
    frame({DEV_W, 8'h04, 8'h9a, 8'h06, 8'h9b}, 1'b1);
    axi_rd(6'h04, 8'h9a, OK);
    axi_rd(6'h05, 8'h00, OK);
    axi_rd(6'h06, 8'h9b, OK);
    axi_wr(irs_pkg::OFS_LINK_CTRL, 8'h00, OK);
    host_u.start();
    host_u.wb(DEV_W, ak);
    host_u.wb(8'h04, ak);
    repeat (4) host_u.put(1'b0, ak);
    host_u.stop();
    axi_rd(6'h04, 8'h9a, OK);
    host_u.start();
    host_u.wb(8'h08, ak);
    chk({7'h0, ak}, 8'h00);
    chk({7'h0, hs_mode}, 8'h01);
    host_u.stop();
    repeat (4) @(posedge clk);
    chk({7'h0, hs_mode}, 8'h00);
    axi_wr(irs_pkg::OFS_LINK_CTRL, 8'h40, OK);
    repeat (2) @(posedge clk);
    chk({7'h0, hs_mode}, 8'h01);
    frame({DEV_W, 8'h04, 8'h5c}, 1'b1);
    axi_wr(irs_pkg::OFS_LINK_CTRL, 8'h10, OK);
    host_u.start();
    for (int i = 7; i >= 0; i--) host_u.put(DEV_W[i], ak);
    #56;
    chk({7'h0, sda_oe}, 8'h01);
    #25000;
    chk({7'h0, sda_oe}, 8'h00);
    host_u.stop();
    finish_test();
  end
endmodule

`default_nettype wire
